// File: src/ssw_pkg.sv
// constants and types for the supply supervisor with watchdog
// assumes a single 100 MHz clock; all intervals derive from it
package ssw_pkg;

   // ----------------------------------------
   // clock and time base
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_US = 1000;                                  // prescaler tick period in us
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;      // cycles per 1 ms tick

   // ----------------------------------------
   // documented durations
   // ----------------------------------------
   localparam int RESET_PULSE_MS = 200;
   localparam int WDOG_TIMEOUT_MS = 1600;                          // 1.60 s
   localparam int RESET_PULSE_TICKS = RESET_PULSE_MS * 1000 / TICK_US;
   localparam int WDOG_TIMEOUT_TICKS = WDOG_TIMEOUT_MS * 1000 / TICK_US;

   // ----------------------------------------
   // kick line decoding
   // ----------------------------------------
   localparam int FLOAT_HOLD_CYCLES = 4;                           // samples needed to call a line floating

   typedef enum logic [1:0] {
      SSW_KICK_LOW,
      SSW_KICK_HIGH,
      SSW_KICK_FLOAT
   } ssw_kick_t;

   typedef enum logic [1:0] {
      SSW_RST_HOLD,
      SSW_RST_STRETCH,
      SSW_RST_IDLE
   } ssw_rst_state_t;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic RESET_N_INIT = 1'b0;
   localparam logic WDOG_N_INIT = 1'b0;
   localparam logic PFAIL_N_INIT = 1'b0;

endpackage

// File: src/ssw_sync.sv
// two-flop synchroniser for a bank of asynchronous inputs
// assumes the inputs are pins outside the clk domain
`timescale 1ns/100ps
module ssw_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // asynchronous side
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] init_val,
   // synchronous side
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;

   // ----------------------------------------
   // two stages; only the second stage is read outside
   // ----------------------------------------
   // reset loads each bit's idle level so no false event follows reset
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         meta_ff <= init_val;
         sync_out <= init_val;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

// File: src/ssw_top.sv
// supply supervisor with watchdog: reset stretcher, manual reset,
// watchdog timer with three-level kick input, power-fail flag gate
// assumes analog comparators outside deliver digital levels and that the
// kick pad reports high, low and a float detect (pull-dither probe)
`timescale 1ns/100ps
module ssw_top
   import ssw_pkg::*;
#(
   parameter int TICK_CYCLES_P = ssw_pkg::TICK_CYCLES,
   parameter int RESET_TICKS_P = ssw_pkg::RESET_PULSE_TICKS,
   parameter int WDOG_TICKS_P = ssw_pkg::WDOG_TIMEOUT_TICKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // supervised inputs, asynchronous
   input wire logic supply_low_in,
   input wire logic power_fail_sense_in,
   input wire logic manual_reset_n_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_kick_float_in,
   // outputs to the host
   output logic sys_reset_n,
   output logic sys_reset,
   output logic watchdog_expired_n,
   output logic power_fail_flag_n,
   output ssw_kick_t kick_state
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   localparam int PW = $clog2(TICK_CYCLES_P + 1);
   localparam int RW = $clog2(RESET_TICKS_P + 1);
   localparam int WW = $clog2(WDOG_TICKS_P + 1);

   initial
   begin
      if (TICK_CYCLES_P < 1 || RESET_TICKS_P < 1 || WDOG_TICKS_P < 2)
      begin
         $error("ssw_top: timing parameters out of range");
      end
   end

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [4:0] raw_in;
   logic [4:0] sync_in;
   logic supply_low_s;
   logic pfail_s;
   logic mr_n_s;
   logic kick_s;
   logic kick_float_s;

   assign raw_in = {supply_low_in, power_fail_sense_in, manual_reset_n_in,
                    watchdog_kick_in, watchdog_kick_float_in};

   ssw_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_in(raw_in),
      .init_val(5'h04), // manual reset idles high
      .sync_out(sync_in)
   );

   assign supply_low_s = sync_in[4];
   assign pfail_s = sync_in[3];
   assign mr_n_s = sync_in[2];
   assign kick_s = sync_in[1];
   assign kick_float_s = sync_in[0];

   // ----------------------------------------
   // shared prescaler: one-cycle tick per TICK_CYCLES_P clocks
   // ----------------------------------------
   logic [PW-1:0] presc_ff;
   logic tick_ff;

   // free-running so both timers share one time base
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         presc_ff <= '0;
         tick_ff <= 1'b0;
      end
      else if (presc_ff == PW'(TICK_CYCLES_P - 1))
      begin
         presc_ff <= '0;
         tick_ff <= 1'b1;
      end
      else
      begin
         presc_ff <= presc_ff + PW'(1);
         tick_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // reset stretcher
   // ----------------------------------------
   ssw_rst_state_t rst_state_ff;
   logic [RW-1:0] rst_cnt_ff;
   logic trigger;

   // both sources are level triggers; holding either keeps reset low
   assign trigger = supply_low_s | ~mr_n_s;

   // a manual input that bounces while stretching returns to hold and
   // restarts the 200 ms count, so bounces merge into one pulse
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rst_state_ff <= SSW_RST_HOLD;
         rst_cnt_ff <= '0;
      end
      else
      begin
         case (rst_state_ff)
            SSW_RST_HOLD:
            begin
               rst_cnt_ff <= '0;
               if (!trigger)
               begin
                  rst_state_ff <= SSW_RST_STRETCH;
               end
            end
            SSW_RST_STRETCH:
            begin
               if (trigger)
               begin
                  rst_state_ff <= SSW_RST_HOLD;
               end
               else if (tick_ff)
               begin
                  if (rst_cnt_ff == RW'(RESET_TICKS_P - 1))
                  begin
                     rst_state_ff <= SSW_RST_IDLE;
                  end
                  else
                  begin
                     rst_cnt_ff <= rst_cnt_ff + RW'(1);
                  end
               end
            end
            SSW_RST_IDLE:
            begin
               if (trigger)
               begin
                  rst_state_ff <= SSW_RST_HOLD;
               end
            end
            default:
            begin
               rst_state_ff <= SSW_RST_HOLD;
            end
         endcase
      end
   end

   // outputs registered; high form is the same flop data inverted
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sys_reset_n <= RESET_N_INIT;
         sys_reset <= ~RESET_N_INIT;
      end
      else
      begin
         sys_reset_n <= (rst_state_ff == SSW_RST_IDLE) && !trigger;
         sys_reset <= !((rst_state_ff == SSW_RST_IDLE) && !trigger);
      end
   end

   // ----------------------------------------
   // kick line decoding
   // ----------------------------------------
   logic [2:0] float_cnt_ff;
   logic kick_prev_ff;
   logic kick_edge;

   // the float probe must persist a few samples so a driven edge with a
   // brief probe glitch does not disable the watchdog
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         float_cnt_ff <= '0;
         kick_state <= SSW_KICK_FLOAT;
      end
      else
      begin
         if (!kick_float_s)
         begin
            float_cnt_ff <= '0;
            kick_state <= kick_s ? SSW_KICK_HIGH : SSW_KICK_LOW;
         end
         else if (float_cnt_ff == 3'(FLOAT_HOLD_CYCLES - 1))
         begin
            kick_state <= SSW_KICK_FLOAT;
         end
         else
         begin
            float_cnt_ff <= float_cnt_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         kick_prev_ff <= 1'b0;
      end
      else
      begin
         kick_prev_ff <= kick_s;
      end
   end

   // only edges while actively driven count as kicks
   assign kick_edge = (kick_s != kick_prev_ff) && !kick_float_s;

   // ----------------------------------------
   // watchdog timer
   // ----------------------------------------
   logic [WW-1:0] wd_cnt_ff;
   logic wd_expired_ff;
   logic wd_clear;

   // reset low clears and holds the count, so timing starts at release
   assign wd_clear = kick_edge || !sys_reset_n;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         wd_cnt_ff <= '0;
         wd_expired_ff <= 1'b0;
      end
      else if (wd_clear)
      begin
         wd_cnt_ff <= '0;
         wd_expired_ff <= 1'b0;
      end
      else if (kick_state == SSW_KICK_FLOAT)
      begin
         wd_cnt_ff <= '0;
      end
      else if (tick_ff && !wd_expired_ff)
      begin
         if (wd_cnt_ff == WW'(WDOG_TICKS_P - 1))
         begin
            wd_expired_ff <= 1'b1;
         end
         else
         begin
            wd_cnt_ff <= wd_cnt_ff + WW'(1);
         end
      end
   end

   // expiry drives only this line; reset comes back only via external wiring
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         watchdog_expired_n <= WDOG_N_INIT;
      end
      else
      begin
         watchdog_expired_n <= !(wd_expired_ff || supply_low_s);
      end
   end

   // ----------------------------------------
   // power-fail flag
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         power_fail_flag_n <= PFAIL_N_INIT;
      end
      else
      begin
         power_fail_flag_n <= pfail_s;
      end
   end

endmodule

// File: bench/ssw_props.sv
// assertions on the supervisor top ports
// assumes one clk domain and sync active-low reset_n
`timescale 1ns/100ps
module ssw_props
   import ssw_pkg::*;
#(
   parameter int TICK_CYCLES_P = 4,
   parameter int RESET_TICKS_P = 5,
   parameter int WDOG_TICKS_P = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins in
   input wire logic supply_low_in,
   input wire logic power_fail_sense_in,
   input wire logic manual_reset_n_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_kick_float_in,
   // pins out
   input wire logic sys_reset_n,
   input wire logic sys_reset,
   input wire logic watchdog_expired_n,
   input wire logic power_fail_flag_n,
   input wire ssw_pkg::ssw_kick_t kick_state
);
   // margins allow for sync delay and prescaler phase
   localparam int SMIN = (RESET_TICKS_P - 1) * TICK_CYCLES_P;
   localparam int SMAX = (RESET_TICKS_P + 1) * TICK_CYCLES_P + 6;
   localparam int WMIN = (WDOG_TICKS_P - 1) * TICK_CYCLES_P;
   localparam int WMAX = (WDOG_TICKS_P + 1) * TICK_CYCLES_P + 8;
   logic [15:0] tg_ff;
   logic [15:0] kg_ff;
   logic kick_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // cycles since a trigger, and since the watchdog was last cleared
   always_ff @(posedge clk)
   begin
      kick_ff <= watchdog_kick_in;
      tg_ff <= (!reset_n || supply_low_in || !manual_reset_n_in) ? 16'h0000 : tg_ff + {15'h0000, !(&tg_ff)};
      kg_ff <= (!reset_n || !sys_reset_n || watchdog_kick_float_in || kick_ff != watchdog_kick_in) ?
               16'h0000 : kg_ff + {15'h0000, !(&kg_ff)};
   end
   AST_MR_LOW: assert property ($fell(manual_reset_n_in) |-> ##[1:4] !sys_reset_n)
      else $error("no manual reset");
   AST_SUP_LOW: assert property (supply_low_in [*5] |-> !sys_reset_n && !watchdog_expired_n)
      else $error("supply low not seen");
   AST_STR_MIN: assert property ($rose(sys_reset_n) |-> tg_ff >= SMIN)
      else $error("reset short");
   AST_STR_MAX: assert property (tg_ff > SMAX |-> sys_reset_n)
      else $error("reset long");
   AST_NO_WD_RST: assert property ($fell(sys_reset_n) |-> tg_ff < 5)
      else $error("reset without trigger");
   AST_PF: assert property ($stable(power_fail_sense_in) [*5] |-> power_fail_flag_n == power_fail_sense_in)
      else $error("power-fail flag wrong");
   AST_WD_MIN: assert property ($fell(watchdog_expired_n) && tg_ff > 5 |-> kg_ff >= WMIN)
      else $error("watchdog early");
   AST_WD_MAX: assert property (kg_ff > WMAX |-> !watchdog_expired_n)
      else $error("watchdog late");
   AST_WD_HOLD: assert property ($rose(watchdog_expired_n) |-> kg_ff < 8 || tg_ff < 8)
      else $error("expired dropped");
   cover property ($rose(sys_reset_n));
   cover property ($fell(watchdog_expired_n) && tg_ff > 5);
   cover property (watchdog_kick_float_in [*6]);
endmodule

// File: bench/ssw_host.sv
// host model: kicks the watchdog, parks the pad
// assumes bench clk; the host stops kicking while in reset
`timescale 1ns/100ps
module ssw_host (
   // control
   input wire logic clk,
   input wire logic kick_en,
   input wire logic float_en,
   input wire logic sys_reset_n,
   // kick pad
   output logic watchdog_kick_in,
   output logic watchdog_kick_float_in
);
   logic [2:0] cnt_ff = 3'h0;
   logic lvl_ff = 1'b0;
   // toggle every 8 cycles; a floating pad gives no stable level
   always @(posedge clk)
   begin
      cnt_ff <= cnt_ff + 3'h1;
      if (kick_en && sys_reset_n && cnt_ff == 3'h7)
         lvl_ff <= !lvl_ff;
   end
   assign watchdog_kick_in = float_en ? cnt_ff[0] : lvl_ff;
   assign watchdog_kick_float_in = float_en;
endmodule

// File: bench/test_supply_supervisor_watchdog.sv
// bench for the supervisor: reset, manual reset, watchdog, power fail
// assumes shortened counts handed to the top parameters
`timescale 1ns/100ps
module test_supply_supervisor_watchdog;
   import ssw_pkg::*;
   localparam int T = 4;
   localparam int R = 5;
   localparam int W = 10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic sup = 1'b0;
   logic pfs = 1'b1;
   logic mr_n = 1'b1;
   logic kick_en = 1'b0;
   logic float_en = 1'b0;
   logic kick, kfl, rst_n, rst, wdo_n, pf_n;
   ssw_kick_t ks;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int rises = 0;
   int n;
   ssw_top #(.TICK_CYCLES_P(T), .RESET_TICKS_P(R), .WDOG_TICKS_P(W)) DUT (.clk(clk), .reset_n(reset_n),
      .supply_low_in(sup), .power_fail_sense_in(pfs), .manual_reset_n_in(mr_n), .watchdog_kick_in(kick),
      .watchdog_kick_float_in(kfl), .sys_reset_n(rst_n), .sys_reset(rst), .watchdog_expired_n(wdo_n),
      .power_fail_flag_n(pf_n), .kick_state(ks));
   ssw_host u_host (.clk(clk), .kick_en(kick_en), .float_en(float_en), .sys_reset_n(rst_n),
      .watchdog_kick_in(kick), .watchdog_kick_float_in(kfl));
   initial
      forever #5 clk = ~clk;
   // cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         end_sim();
      end
   end
   always @(posedge rst_n)
      rises++;
   task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge clk);
   endtask
   // bounded wait for reset or expired to reach a level
   task automatic wait_for(input bit wd, input logic v);
      n = 0;
      while ((wd ? wdo_n : rst_n) !== v && n < 80)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   function automatic logic [1:0] in_rng(input int lo, input int hi);
      return {1'b0, n >= lo && n <= hi};
   endfunction
   task automatic t_por();
      step(1);
      chk("por_rst", {rst_n, rst}, 2'h1);
      chk("por_wdo_pf", {wdo_n, pf_n}, 2'h0);
      chk("por_ks", ks, SSW_KICK_FLOAT);
      @(posedge clk);
      reset_n <= 1'b1;
      wait_for(1'b0, 1'b1);
      chk("por_len", in_rng(R*T-T, R*T+T+4), 2'h1);
      $display("por done");
   endtask
   task automatic t_pf();
      @(posedge clk);
      pfs <= 1'b0;
      step(5);
      chk("pf_low", pf_n, 2'h0);
      @(posedge clk);
      pfs <= 1'b1;
      step(5);
      chk("pf_high", pf_n, 2'h1);
      $display("pf done");
   endtask
   // bouncing switch must give one pulse
   task automatic t_mr();
      int r0;
      r0 = rises;
      @(posedge clk);
      mr_n <= 1'b0;
      step(4);
      chk("mr_on", {rst_n, rst}, 2'h1);
      @(posedge clk);
      mr_n <= 1'b1;
      step(3);
      @(posedge clk);
      mr_n <= 1'b0;
      step(3);
      @(posedge clk);
      mr_n <= 1'b1;
      wait_for(1'b0, 1'b1);
      chk("mr_len", in_rng(R*T-T, R*T+T+4), 2'h1);
      chk("mr_pulses", 2'(rises - r0), 2'h1);
      $display("mr done");
   endtask
   task automatic t_wd();
      @(posedge clk);
      kick_en <= 1'b1;
      step(100);
      chk("wd_kicked", wdo_n, 2'h1);
      @(posedge clk);
      kick_en <= 1'b0;
      step(6);
      chk("wd_ks", ks, {1'b0, kick});
      wait_for(1'b1, 1'b0);
      chk("wd_time", in_rng(W*T-T-14, W*T+T+8), 2'h1);
      step(30);
      chk("wd_latch", {wdo_n, rst_n}, 2'h1);
      @(posedge clk);
      kick_en <= 1'b1;
      wait_for(1'b1, 1'b1);
      chk("wd_clear", in_rng(0, 13), 2'h1);
      $display("wd done");
   endtask
   task automatic t_float();
      @(posedge clk);
      kick_en <= 1'b0;
      float_en <= 1'b1;
      step(8);
      chk("fl_ks", ks, SSW_KICK_FLOAT);
      step(80);
      chk("fl_wdo", wdo_n, 2'h1);
      @(posedge clk);
      float_en <= 1'b0;
      kick_en <= 1'b1;
      $display("float done");
   endtask
   task automatic t_sup();
      @(posedge clk);
      sup <= 1'b1;
      step(5);
      chk("sup_on", {rst_n, wdo_n}, 2'h0);
      step(40);
      chk("sup_hold", {rst_n, rst}, 2'h1);
      @(posedge clk);
      sup <= 1'b0;
      step(5);
      chk("sup_wdo", wdo_n, 2'h1);
      wait_for(1'b0, 1'b1);
      chk("sup_len", in_rng(R*T-T-5, R*T+T-1), 2'h1);
      $display("sup done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      step(2);
      t_por();
      t_pf();
      t_mr();
      t_wd();
      t_float();
      t_sup();
      end_sim();
   end
endmodule
bind ssw_top ssw_props #(.TICK_CYCLES_P(TICK_CYCLES_P), .RESET_TICKS_P(RESET_TICKS_P),
   .WDOG_TICKS_P(WDOG_TICKS_P)) u_props (.clk(clk), .reset_n(reset_n), .supply_low_in(supply_low_in),
   .power_fail_sense_in(power_fail_sense_in), .manual_reset_n_in(manual_reset_n_in),
   .watchdog_kick_in(watchdog_kick_in), .watchdog_kick_float_in(watchdog_kick_float_in),
   .sys_reset_n(sys_reset_n), .sys_reset(sys_reset), .watchdog_expired_n(watchdog_expired_n),
   .power_fail_flag_n(power_fail_flag_n), .kick_state(kick_state));
